/* fspo_pkg.sv */
// Package of register map, field positions and codes for the fault shutdown block
package fspo_pkg;
   localparam int unsigned FSPO_CH = 8;
   localparam int unsigned FSPO_AW = 8;
   // Register byte addresses
   localparam logic [7:0] FSPO_A_CTRL = 8'h00;
   localparam logic [7:0] FSPO_A_IN_EN = 8'h04;
   localparam logic [7:0] FSPO_A_LATCH = 8'h08;
   localparam logic [7:0] FSPO_A_FUNC_EN = 8'h0C;
   localparam logic [7:0] FSPO_A_DIR = 8'h10;
   localparam logic [7:0] FSPO_A_VALUE = 8'h14;
   localparam logic [7:0] FSPO_A_CMP = 8'h18;
   localparam logic [7:0] FSPO_A_IRQ_STAT = 8'h1C;
   localparam logic [7:0] FSPO_A_IRQ_EN = 8'h20;
   localparam logic [7:0] FSPO_A_IRQ_CLR = 8'h24;
   // Control register fields
   localparam int unsigned FSPO_B_FLAG = 0;
   localparam int unsigned FSPO_B_FAULT_IRQ_ENABLE = 1;
   localparam int unsigned FSPO_B_GEN = 2;
   localparam int unsigned FSPO_B_FORCE = 3;
   // Comparator register fields
   localparam int unsigned FSPO_B_CMODE = 0;
   localparam int unsigned FSPO_B_CIE = 2;
   localparam int unsigned FSPO_B_CFLAG = 3;
   localparam int unsigned FSPO_B_CRES = 4;
   // Interrupt status fields
   localparam int unsigned FSPO_B_EV_FAULT = 0;
   localparam int unsigned FSPO_B_EV_CMP = 1;
   localparam int unsigned FSPO_NEV = 2;
   // Fixed wiring
   localparam int unsigned FSPO_CMP_INPUT = 2;
   localparam int unsigned FSPO_PWM_OUT = 7;
   // Comparator interrupt modes
   typedef enum logic [1:0] {
      FSPO_CM_NONE = 2'h0,
      FSPO_CM_RISE = 2'h1,
      FSPO_CM_FALL = 2'h2,
      FSPO_CM_BOTH = 2'h3
   } fspo_cmode_e;
   // Reset values and bus answers
   localparam logic [7:0] FSPO_RST_BYTE = 8'h00;
   localparam logic [1:0] FSPO_CMODE_RST = 2'h0;
   localparam logic [1:0] FSPO_RESP_OK = 2'h0;
   localparam logic [1:0] FSPO_RESP_ERR = 2'h2;
endpackage

/* fspo_cmp_edge.sv */
// Comparator result synchroniser, edge interrupt and sticky comparator flag
`timescale 1ns/10ps
module fspo_cmp_edge
   import fspo_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Analog comparator result, asynchronous
   input wire logic comparator_result_async,
   // Configuration
   input wire logic [1:0] comparator_irq_mode,
   input wire logic comparator_irq_enable,
   input wire logic flag_clear,
   // Status
   output logic comparator_result,
   output logic comparator_flag_q,
   output logic edge_seen,
   output logic irq_d
);
   logic sync1_q;
   logic sync2_q;
   logic prev_q;
   logic rise;
   logic fall;
   logic flag_d;

   assign rise = sync2_q & ~prev_q;
   assign fall = ~sync2_q & prev_q;
   assign comparator_result = sync2_q;

   // [RQ10] Edge mode select
   assign edge_seen = (comparator_irq_mode == FSPO_CM_BOTH) ? (rise | fall) :
                      (comparator_irq_mode == FSPO_CM_RISE) ? rise :
                      (comparator_irq_mode == FSPO_CM_FALL) ? fall : 1'b0;
   // Set wins over a clear in the same cycle
   assign flag_d = edge_seen | (comparator_flag_q & ~flag_clear);
   // Disabled interrupt delivers no fault event
   assign irq_d = flag_d & comparator_irq_enable;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         prev_q <= 1'b0;
         comparator_flag_q <= 1'b0;
      end else begin
         sync1_q <= comparator_result_async;
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
         comparator_flag_q <= flag_d;
      end
   end
endmodule

/* fspo_top.sv */
// Fault detect and pin shutdown block with AXI4-Lite register slave
//
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/10ps
// Behaviour
// [RQ1] Comparator interrupt feeds fault input two
// [RQ2] Enabled fault replaces PWM with safe value
// [RQ3] Pin forced on the comparator interrupt edge
// [RQ4] Release after source gone, flags cleared
// [RQ5] Software clears fault flag writing zero
// [RQ6] Per-input enable bits; input two enables comparator
// [RQ7] Output seven controls PWM timer zero pin
// [RQ8] Direction one drives pin during fault
// [RQ9] Value bit picks driven level, zero low
// [RQ10] Mode three: interrupt on both edges
// [RQ11] Software must enable comparator interrupt
// [RQ12] Enabled fault latches input, sets flag
// [RQ13] Function enable zero keeps pin bypassed
// [RQ14] Fault state: high, low or hi-z
// [RQ15] Global enable gates all fault detection
module fspo_top
   import fspo_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data
   input wire logic awvalid,
   output logic awready,
   input wire logic [FSPO_AW-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // AXI4-Lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read
   input wire logic arvalid,
   output logic arready,
   input wire logic [FSPO_AW-1:0] araddr,
   input wire logic [2:0] arprot,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // Fault sources on the bus clock; bit 2 is unused
   input wire logic [FSPO_CH-1:0] fault_src,
   // Analog comparator result, asynchronous
   input wire logic comparator_result_async,
   // Peripheral pin functions, PWM timer zero channel one on bit 7
   input wire logic [FSPO_CH-1:0] periph_out,
   input wire logic [FSPO_CH-1:0] periph_oe_n,
   // Port pins
   output logic [FSPO_CH-1:0] pin_out,
   output logic [FSPO_CH-1:0] pin_oe_n,
   // Interrupt
   output logic irq
);
   // Registers
   logic fault_flag_q;
   logic fault_irq_enable_q;
   logic shutdown_global_enable_q;
   logic [FSPO_CH-1:0] input_enable_q;
   logic [FSPO_CH-1:0] latched_input_reg_q;
   logic [FSPO_CH-1:0] func_enable_q;
   logic [FSPO_CH-1:0] direction_q;
   logic [FSPO_CH-1:0] value_q;
   logic [1:0] comparator_irq_mode_q;
   logic comparator_irq_enable_q;
   logic [FSPO_NEV-1:0] irq_stat_q;
   logic [FSPO_NEV-1:0] irq_en_q;
   // Bus state
   logic aw_have_q;
   logic w_have_q;
   logic [FSPO_AW-1:0] waddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic [31:0] rdata_d;
   logic rd_hit;
   // Comparator
   logic comparator_result;
   logic comparator_flag_q;
   logic cmp_edge;
   logic cmp_irq_d;

   // Write path decode
   logic aw_take;
   logic w_take;
   logic wr_go;
   logic wr_hit;
   logic wr_byte;
   logic [7:0] wb;
   assign aw_take = awvalid & awready;
   assign w_take = wvalid & wready;
   assign wr_go = aw_have_q & w_have_q & ~bvalid;
   assign wb = wdata_q[7:0];
   assign wr_byte = wr_go & wstrb_q[0];
   logic wr_ctrl;
   logic wr_inen;
   logic wr_latch;
   logic wr_fen;
   logic wr_dir;
   logic wr_val;
   logic wr_cmp;
   logic wr_ien;
   logic wr_iclr;
   assign wr_ctrl = wr_byte & (waddr_q == FSPO_A_CTRL);
   assign wr_inen = wr_byte & (waddr_q == FSPO_A_IN_EN);
   assign wr_latch = wr_byte & (waddr_q == FSPO_A_LATCH);
   assign wr_fen = wr_byte & (waddr_q == FSPO_A_FUNC_EN);
   assign wr_dir = wr_byte & (waddr_q == FSPO_A_DIR);
   assign wr_val = wr_byte & (waddr_q == FSPO_A_VALUE);
   assign wr_cmp = wr_byte & (waddr_q == FSPO_A_CMP);
   assign wr_ien = wr_byte & (waddr_q == FSPO_A_IRQ_EN);
   assign wr_iclr = wr_byte & (waddr_q == FSPO_A_IRQ_CLR);
   assign wr_hit = (waddr_q == FSPO_A_CTRL) | (waddr_q == FSPO_A_IN_EN) |
                   (waddr_q == FSPO_A_LATCH) | (waddr_q == FSPO_A_FUNC_EN) |
                   (waddr_q == FSPO_A_DIR) | (waddr_q == FSPO_A_VALUE) |
                   (waddr_q == FSPO_A_CMP) | (waddr_q == FSPO_A_IRQ_STAT) |
                   (waddr_q == FSPO_A_IRQ_EN) | (waddr_q == FSPO_A_IRQ_CLR);

   // [RQ5] Writing zero to flag bit clears it
   logic fault_flag_clr;
   logic cmp_flag_clr;
   logic force_fault;
   assign fault_flag_clr = wr_ctrl & ~wb[FSPO_B_FLAG];
   assign cmp_flag_clr = wr_cmp & ~wb[FSPO_B_CFLAG];
   assign force_fault = wr_ctrl & wb[FSPO_B_FORCE] & wb[FSPO_B_GEN];

   fspo_cmp_edge u_cmp (
      .aclk(aclk),
      .aresetn(aresetn),
      .comparator_result_async(comparator_result_async),
      .comparator_irq_mode(comparator_irq_mode_q),
      .comparator_irq_enable(comparator_irq_enable_q),
      .flag_clear(cmp_flag_clr),
      .comparator_result(comparator_result),
      .comparator_flag_q(comparator_flag_q),
      .edge_seen(cmp_edge),
      .irq_d(cmp_irq_d)
   );

   // [RQ1] Comparator interrupt on fault input two
   logic [FSPO_CH-1:0] fault_in;
   assign fault_in = {fault_src[FSPO_CH-1:FSPO_CMP_INPUT+1], cmp_irq_d,
                      fault_src[FSPO_CMP_INPUT-1:0]};

   // [RQ6] Per-input enable; [RQ15] global gate
   logic [FSPO_CH-1:0] fault_hit;
   logic any_hit;
   assign fault_hit = fault_in & input_enable_q & {FSPO_CH{shutdown_global_enable_q}};
   assign any_hit = |fault_hit;

   // [RQ12] Latch inputs and set flag; set wins
   logic [FSPO_CH-1:0] latched_d;
   logic fault_flag_d;
   assign latched_d = fault_hit | (latched_input_reg_q & ~({FSPO_CH{wr_latch}} & wb));
   assign fault_flag_d = any_hit | force_fault | (fault_flag_q & ~fault_flag_clr);

   // [RQ4] Held while a source or the flag remains
   logic shutdown_d;
   assign shutdown_d = shutdown_global_enable_q & (any_hit | fault_flag_d);

   // Next value of each pin; stays combinational so the pin flops on the interrupt edge
   logic [FSPO_CH-1:0] pin_out_d;
   logic [FSPO_CH-1:0] pin_oe_n_d;
   genvar gi;
   generate
      for (gi = 0; gi < FSPO_CH; gi++) begin : g_pin
         logic ovr;
         // [RQ13] Function enable zero means bypass
         assign ovr = func_enable_q[gi] & shutdown_d;
         // [RQ2] [RQ9] Safe level replaces peripheral
         assign pin_out_d[gi] = ovr ? value_q[gi] : periph_out[gi];
         // [RQ8] [RQ14] Direction zero leaves pin undriven
         assign pin_oe_n_d[gi] = ovr ? ~direction_q[gi] : periph_oe_n[gi];
      end
   endgenerate

   // [RQ3] [RQ7] Pin flops on the same edge as the comparator flag
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_out <= FSPO_RST_BYTE;
         pin_oe_n <= ~FSPO_RST_BYTE;
      end else begin
         pin_out <= pin_out_d;
         pin_oe_n <= pin_oe_n_d;
      end
   end

   // Sticky interrupt status, set wins over clear
   logic [FSPO_NEV-1:0] ev;
   logic [FSPO_NEV-1:0] irq_stat_d;
   assign ev[FSPO_B_EV_FAULT] = fault_flag_d & ~fault_flag_q & fault_irq_enable_q;
   assign ev[FSPO_B_EV_CMP] = cmp_edge;
   assign irq_stat_d = ev | (irq_stat_q & ~({FSPO_NEV{wr_iclr}} & wb[FSPO_NEV-1:0]));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fault_flag_q <= 1'b0;
         latched_input_reg_q <= FSPO_RST_BYTE;
         irq_stat_q <= '0;
         irq <= 1'b0;
      end else begin
         fault_flag_q <= fault_flag_d;
         latched_input_reg_q <= latched_d;
         irq_stat_q <= irq_stat_d;
         irq <= |(irq_stat_d & irq_en_q);
      end
   end

   // Software configuration registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fault_irq_enable_q <= 1'b0;
         shutdown_global_enable_q <= 1'b0;
         input_enable_q <= FSPO_RST_BYTE;
         func_enable_q <= FSPO_RST_BYTE;
         direction_q <= FSPO_RST_BYTE;
         value_q <= FSPO_RST_BYTE;
         comparator_irq_mode_q <= FSPO_CMODE_RST;
         comparator_irq_enable_q <= 1'b0;
         irq_en_q <= '0;
      end else begin
         if (wr_ctrl) begin
            fault_irq_enable_q <= wb[FSPO_B_FAULT_IRQ_ENABLE];
            shutdown_global_enable_q <= wb[FSPO_B_GEN];
         end
         if (wr_inen) begin
            input_enable_q <= wb;
         end
         if (wr_fen) begin
            func_enable_q <= wb;
         end
         if (wr_dir) begin
            direction_q <= wb;
         end
         if (wr_val) begin
            value_q <= wb;
         end
         // [RQ11] Interrupt enable belongs to software
         if (wr_cmp) begin
            comparator_irq_mode_q <= wb[FSPO_B_CMODE+1:FSPO_B_CMODE];
            comparator_irq_enable_q <= wb[FSPO_B_CIE];
         end
         if (wr_ien) begin
            irq_en_q <= wb[FSPO_NEV-1:0];
         end
      end
   end

   // Write channel: address and data taken in either order
   logic aw_have_d;
   logic w_have_d;
   logic bvalid_d;
   assign aw_have_d = (aw_have_q | aw_take) & ~wr_go;
   assign w_have_d = (w_have_q | w_take) & ~wr_go;
   assign bvalid_d = wr_go | (bvalid & ~bready);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= FSPO_RESP_OK;
         waddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end else begin
         aw_have_q <= aw_have_d;
         w_have_q <= w_have_d;
         // No new beat until the response is gone
         awready <= ~aw_have_d & ~bvalid_d;
         wready <= ~w_have_d & ~bvalid_d;
         bvalid <= bvalid_d;
         if (wr_go) begin
            bresp <= wr_hit ? FSPO_RESP_OK : FSPO_RESP_ERR;
         end
         if (aw_take) begin
            waddr_q <= awaddr;
         end
         if (w_take) begin
            wdata_q <= wdata;
            wstrb_q <= wstrb;
         end
      end
   end

   // Read mux; clear register reads as zero
   logic [7:0] ctrl_rd;
   logic [7:0] cmp_rd;
   assign ctrl_rd = {4'h0, 1'b0, shutdown_global_enable_q, fault_irq_enable_q, fault_flag_q};
   assign cmp_rd = {3'h0, comparator_result, comparator_flag_q, comparator_irq_enable_q,
                    comparator_irq_mode_q};
   always_comb begin
      rdata_d = 32'h0000_0000;
      rd_hit = 1'b1;
      unique case (araddr)
         FSPO_A_CTRL: rdata_d[7:0] = ctrl_rd;
         FSPO_A_IN_EN: rdata_d[7:0] = input_enable_q;
         FSPO_A_LATCH: rdata_d[7:0] = latched_input_reg_q;
         FSPO_A_FUNC_EN: rdata_d[7:0] = func_enable_q;
         FSPO_A_DIR: rdata_d[7:0] = direction_q;
         FSPO_A_VALUE: rdata_d[7:0] = value_q;
         FSPO_A_CMP: rdata_d[7:0] = cmp_rd;
         FSPO_A_IRQ_STAT: rdata_d[FSPO_NEV-1:0] = irq_stat_q;
         FSPO_A_IRQ_EN: rdata_d[FSPO_NEV-1:0] = irq_en_q;
         FSPO_A_IRQ_CLR: rd_hit = 1'b1;
         default: rd_hit = 1'b0;
      endcase
   end

   // Read channel: one outstanding read
   logic ar_take;
   logic rvalid_d;
   assign ar_take = arvalid & arready;
   assign rvalid_d = ar_take | (rvalid & ~rready);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= FSPO_RESP_OK;
      end else begin
         arready <= ~rvalid_d;
         rvalid <= rvalid_d;
         if (ar_take) begin
            rdata <= rdata_d;
            rresp <= rd_hit ? FSPO_RESP_OK : FSPO_RESP_ERR;
         end
      end
   end
endmodule

/* fspo_monitor.sv */
// Port-level assertions for the fault shutdown block
`timescale 1ns/10ps
module fspo_monitor
   import fspo_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Write channels
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [1:0] bresp,
   // Read channels
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   // Pins and interrupt
   input wire logic [FSPO_CH-1:0] pin_out,
   input wire logic [FSPO_CH-1:0] pin_oe_n,
   input wire logic irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   chk_reset_pins_idle: assert property ($rose(aresetn) |->
      pin_oe_n == 8'hFF && pin_out == 8'h00 && !irq)
      else $error("pins or irq not idle after reset");
   chk_bresp_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped early");
   chk_rdata_holds: assert property (rvalid && !rready |=>
      rvalid && $stable(rdata) && $stable(rresp))
      else $error("read data dropped early");
   chk_write_answer: assert property (awvalid && awready && wvalid && wready |->
      ##[1:2] bvalid)
      else $error("write not answered in time");
   chk_read_answer: assert property (arvalid && arready |-> ##[1:2] rvalid)
      else $error("read not answered in time");
   chk_write_busy: assert property (bvalid |-> !awready && !wready)
      else $error("write taken with response pending");
   chk_read_busy: assert property (rvalid |-> !arready)
      else $error("read taken with data pending");
   chk_err_data_zero: assert property (rvalid && rresp == FSPO_RESP_ERR |->
      rdata == 32'h0)
      else $error("error read returned data");
   chk_upper_zero: assert property (rvalid |-> rdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   chk_bresp_codes: assert property (bvalid |->
      bresp == FSPO_RESP_OK || bresp == FSPO_RESP_ERR)
      else $error("unknown write response code");
endmodule

/* fspo_partner.sv */
// PWM timer channel and comparator source on the far side of the shutdown block
`timescale 1ns/10ps
module fspo_partner
   import fspo_pkg::*;
(
   // Clock and command
   input wire logic aclk,
   input wire logic cmp_level,
   // Comparator output, asynchronous
   output logic comparator_result_async,
   // Peripheral pin functions
   output logic [FSPO_CH-1:0] periph_out,
   output logic [FSPO_CH-1:0] periph_oe_n
);
   logic [7:0] cnt_q = 8'h00;
   always_ff @(posedge aclk) begin
      cnt_q <= cnt_q + 8'h01;
   end
   assign periph_out = {cnt_q[3], cnt_q[6:0]};
   assign periph_oe_n = {1'b0, ~cnt_q[6:0]};
   initial comparator_result_async = 1'b0;
   // Off-grid delay keeps the comparator unrelated to the clock
   always @(cmp_level) begin
      comparator_result_async <= #3 cmp_level;
   end
endmodule

/* fspo_top_bench.sv */
// Self-checking bench for the fault shutdown block
`timescale 1ns/10ps
module fspo_top_bench
   import fspo_pkg::*;
;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic cmp_level = 0, comparator_result_async, awready, wready, bvalid, arready, rvalid, irq;
   logic [7:0] awaddr = 0, araddr = 0, fault_src = 0, periph_out, periph_oe_n, pin_out, pin_oe_n;
   logic [7:0] dv, vv;
   logic [31:0] wdata = 0, rdata;
   logic [1:0] bresp, rresp;
   int n_mismatch = 0, total_checks = 0, n;
   logic [7:0] regs [10] = '{FSPO_A_CTRL, FSPO_A_IN_EN, FSPO_A_LATCH, FSPO_A_FUNC_EN, FSPO_A_DIR,
      FSPO_A_VALUE, FSPO_A_CMP, FSPO_A_IRQ_STAT, FSPO_A_IRQ_EN, FSPO_A_IRQ_CLR};
   always #5 aclk = ~aclk;
   fspo_top i_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
      .wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
      .rdata(rdata), .rresp(rresp), .fault_src(fault_src),
      .comparator_result_async(comparator_result_async), .periph_out(periph_out),
      .periph_oe_n(periph_oe_n), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .irq(irq));
   fspo_partner i_partner (.aclk(aclk), .cmp_level(cmp_level),
      .comparator_result_async(comparator_result_async), .periph_out(periph_out),
      .periph_oe_n(periph_oe_n));
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      int k;
      @(posedge aclk);
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      awaddr <= a;
      wdata <= {24'h0, d};
      bready <= 1'b1;
      k = 0;
      do begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
         k++;
      end while (bvalid !== 1'b1 && k < 50);
      bready <= 1'b0;
      // A response that never came counts as a mismatch
      check({31'h0, bvalid}, 32'h1);
      check({30'h0, bresp}, {30'h0, er});
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
      int k;
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      k = 0;
      do begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'b0;
         k++;
      end while (rvalid !== 1'b1 && k < 50);
      rready <= 1'b0;
      check({31'h0, rvalid}, 32'h1);
      check(rdata, {24'h0, e});
      check({30'h0, rresp}, {30'h0, er});
   endtask
   // Pins pass the function one cycle late unless overridden
   task automatic pins(input logic [7:0] ov, input logic [7:0] val, input logic [7:0] dir);
      logic [7:0] po, pe;
      @(posedge aclk);
      po = periph_out;
      pe = periph_oe_n;
      @(posedge aclk);
      check({24'h0, pin_out}, {24'h0, (ov & val) | (~ov & po)});
      check({24'h0, pin_oe_n}, {24'h0, (ov & ~dir) | (~ov & pe)});
   endtask
   initial begin
      #200000;
      n_mismatch++;
      results();
   end
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (regs[i]) rd(regs[i], 8'h00, FSPO_RESP_OK);
      rd(8'h3C, 8'h00, FSPO_RESP_ERR);
      wr(8'h3C, 8'hFF, FSPO_RESP_ERR);
      pins(8'h00, 8'h00, 8'h00);
      $display("reset test done");
      wr(FSPO_A_IN_EN, 8'h04, FSPO_RESP_OK);
      wr(FSPO_A_FUNC_EN, 8'h80, FSPO_RESP_OK);
      wr(FSPO_A_VALUE, 8'h00, FSPO_RESP_OK);
      wr(FSPO_A_CMP, 8'h07, FSPO_RESP_OK);
      wr(FSPO_A_CTRL, 8'h04, FSPO_RESP_OK);
      // Direction still zero: the PWM drives, so a released pin marks the override
      cmp_level <= 1'b1;
      n = 0;
      while (pin_oe_n[7] !== 1'b1 && n < 10) begin
         @(posedge aclk);
         n++;
      end
      // Two synchroniser stages, the flag edge, then one sampling edge
      check(n, 4);
      pins(8'h80, 8'h00, 8'h00);
      wr(FSPO_A_DIR, 8'h80, FSPO_RESP_OK);
      pins(8'h80, 8'h00, 8'h80);
      rd(FSPO_A_LATCH, 8'h04, FSPO_RESP_OK);
      rd(FSPO_A_CTRL, 8'h05, FSPO_RESP_OK);
      rd(FSPO_A_CMP, 8'h1F, FSPO_RESP_OK);
      wr(FSPO_A_CTRL, 8'h04, FSPO_RESP_OK);
      pins(8'h80, 8'h00, 8'h80);
      cmp_level <= 1'b0;
      // Two synchroniser stages plus the edge register
      repeat (5) @(posedge aclk);
      rd(FSPO_A_CMP, 8'h0F, FSPO_RESP_OK);
      // level back below threshold before clearing
      wr(FSPO_A_CMP, 8'h07, FSPO_RESP_OK);
      pins(8'h80, 8'h00, 8'h80);
      wr(FSPO_A_LATCH, 8'h04, FSPO_RESP_OK);
      wr(FSPO_A_CTRL, 8'h04, FSPO_RESP_OK);
      pins(8'h00, 8'h00, 8'h00);
      $display("comparator test done");
      wr(FSPO_A_IN_EN, 8'h01, FSPO_RESP_OK);
      wr(FSPO_A_FUNC_EN, 8'h0F, FSPO_RESP_OK);
      for (int s = 0; s < 3; s++) begin
         dv = (s < 2) ? 8'h0F : 8'h00;
         vv = (s == 0) ? 8'h0F : 8'h00;
         wr(FSPO_A_DIR, dv, FSPO_RESP_OK);
         wr(FSPO_A_VALUE, vv, FSPO_RESP_OK);
         fault_src <= 8'h01;
         pins(8'h0F, vv, dv);
         fault_src <= 8'h00;
         wr(FSPO_A_LATCH, 8'h01, FSPO_RESP_OK);
         wr(FSPO_A_CTRL, 8'h04, FSPO_RESP_OK);
         pins(8'h00, 8'h00, 8'h00);
      end
      $display("safe state test done");
      wr(FSPO_A_CTRL, 8'h00, FSPO_RESP_OK);
      fault_src <= 8'h01;
      pins(8'h00, 8'h00, 8'h00);
      rd(FSPO_A_LATCH, 8'h00, FSPO_RESP_OK);
      fault_src <= 8'h00;
      wr(FSPO_A_IN_EN, 8'h04, FSPO_RESP_OK);
      wr(FSPO_A_CTRL, 8'h04, FSPO_RESP_OK);
      fault_src <= 8'h04;
      pins(8'h00, 8'h00, 8'h00);
      rd(FSPO_A_LATCH, 8'h00, FSPO_RESP_OK);
      fault_src <= 8'h00;
      $display("gating test done");
      rd(FSPO_A_IRQ_STAT, 8'h02, FSPO_RESP_OK);
      wr(FSPO_A_IRQ_EN, 8'h02, FSPO_RESP_OK);
      @(posedge aclk);
      check(irq, 1);
      wr(FSPO_A_IRQ_EN, 8'h00, FSPO_RESP_OK);
      @(posedge aclk);
      check(irq, 0);
      wr(FSPO_A_IRQ_CLR, 8'h03, FSPO_RESP_OK);
      rd(FSPO_A_IRQ_STAT, 8'h00, FSPO_RESP_OK);
      wr(FSPO_A_IRQ_EN, 8'h03, FSPO_RESP_OK);
      wr(FSPO_A_IN_EN, 8'h01, FSPO_RESP_OK);
      wr(FSPO_A_CTRL, 8'h06, FSPO_RESP_OK);
      fault_src <= 8'h01;
      repeat (3) @(posedge aclk);
      check(irq, 1);
      rd(FSPO_A_IRQ_STAT, 8'h01, FSPO_RESP_OK);
      fault_src <= 8'h00;
      wr(FSPO_A_LATCH, 8'h01, FSPO_RESP_OK);
      wr(FSPO_A_CTRL, 8'h06, FSPO_RESP_OK);
      wr(FSPO_A_IRQ_CLR, 8'h01, FSPO_RESP_OK);
      @(posedge aclk);
      check(irq, 0);
      $display("interrupt test done");
      wr(FSPO_A_IN_EN, 8'h04, FSPO_RESP_OK);
      // Interrupt left off: rise and fall modes set the flag but never latch a fault
      for (int m = 0; m < 3; m++) begin
         wr(FSPO_A_CMP, m[7:0], FSPO_RESP_OK);
         cmp_level <= 1'b1;
         repeat (5) @(posedge aclk);
         rd(FSPO_A_CMP, {3'h0, 1'b1, (m == 1), 1'b0, m[1:0]}, FSPO_RESP_OK);
         cmp_level <= 1'b0;
         repeat (5) @(posedge aclk);
         rd(FSPO_A_CMP, {4'h0, (m != 0), 1'b0, m[1:0]}, FSPO_RESP_OK);
         rd(FSPO_A_LATCH, 8'h00, FSPO_RESP_OK);
      end
      $display("comparator mode test done");
      results();
   end
endmodule
bind fspo_top fspo_monitor i_mon (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
   .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
   .bresp(bresp), .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
   .rdata(rdata), .rresp(rresp), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .irq(irq));
